//--- cpsb_consts.svh
`ifndef CPSB_CONSTS_SVH
`define CPSB_CONSTS_SVH

`define CPSB_ADDR_SYS_CTRL     8'h92
`define CPSB_ADDR_GEN_CTRL     8'hd0
`define CPSB_ADDR_FPU_ACK      8'hf0

`define CPSB_SYS_CTRL_RESET    8'h00
`define CPSB_GEN_CTRL_RESET    32'h00000000
`define CPSB_SYS_CTRL_MASK_BIT 1
`define CPSB_GEN_CTRL_FPU_BIT  13

`define CPSB_STRAP_ADDR_MASK   0
`define CPSB_STRAP_IGNORE_ERR  1
`define CPSB_STRAP_IRQ         2
`define CPSB_STRAP_NMI         3

`define CPSB_INIT_CYCLES       16

`endif

//--- cpsb_pkg.sv
package cpsb_pkg;

  typedef enum logic
  {
    CPSB_INIT_IDLE,
    CPSB_INIT_PULSE
  } cpsb_init_state_t;

endpackage

//--- cpsb_sync.sv
module cpsb_sync
  import cpsb_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      stage1 <= RESET_VAL;
      o_sync <= RESET_VAL;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

//--- cpsb_init_pulse.sv
`include "cpsb_consts.svh"
module cpsb_init_pulse
  import cpsb_pkg::*;
#(
  parameter int CYCLES = `CPSB_INIT_CYCLES
)
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_trigger,
  input  wire logic i_hold,
  output logic      o_active
);

  localparam int CW = $clog2(CYCLES + 1);

  cpsb_init_state_t state;
  cpsb_init_state_t next_state;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             next_active;

  always_comb
  begin
    next_state  = state;
    next_count  = count;
    case (state)
      CPSB_INIT_IDLE:
      begin
        if (i_trigger)
        begin
          next_state = CPSB_INIT_PULSE;
          next_count = CW'(CYCLES - 1);
        end
      end
      CPSB_INIT_PULSE:
      begin
        // a trigger during a pulse is merged, not restarted
        if (count == '0)
          next_state = CPSB_INIT_IDLE;
        else
          next_count = count - 1'b1;
      end
      default:
      begin
        next_state = CPSB_INIT_IDLE;
        next_count = '0;
      end
    endcase
    next_active = (next_state == CPSB_INIT_PULSE) || i_hold;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state    <= CPSB_INIT_IDLE;
      count    <= '0;
      o_active <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      count    <= next_count;
      o_active <= next_active;
    end
  end

endmodule

//--- cpsb_top.sv
`include "cpsb_consts.svh"
module cpsb_top
  import cpsb_pkg::*;
#(
  parameter int SMI_SRC     = 4,
  parameter int INIT_CYCLES = `CPSB_INIT_CYCLES
)
(
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  // register access port
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [31:0]        i_reg_wdata,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  output logic      [31:0]        o_reg_rdata,
  // pins and loose control
  input  wire logic               i_power_good_in,
  input  wire logic               i_fpu_error_in_n,
  input  wire logic               i_kbc_reset_in_n,
  input  wire logic               i_kbc_mask_gate_in,
  input  wire logic               i_system_error_in_n,
  input  wire logic               i_io_check_error_in_n,
  input  wire logic [3:0]         i_speed_strap_bits,
  input  wire logic               i_bist_enable,
  input  wire logic               i_sw_init_req,
  input  wire logic               i_cpu_sleep_enable,
  input  wire logic               i_s1_entry,
  input  wire logic               i_irq_pending,
  input  wire logic               i_nmi_system_error_in_disable,
  input  wire logic               i_nmi_io_check_error_in_disable,
  input  wire logic [SMI_SRC-1:0] i_smi_event,
  input  wire logic [SMI_SRC-1:0] i_smi_enable,
  input  wire logic               i_stop_clock_req,
  output logic                    o_pci_bus_reset_n,
  output logic                    o_fpu_irq_line,
  output logic                    o_addr_bit20_mask_out_o,
  output logic                    o_addr_bit20_mask_out_oe,
  output logic                    o_cpu_sleep_out_o,
  output logic                    o_cpu_sleep_out_oe,
  output logic                    o_ignore_fpu_error_out_o,
  output logic                    o_ignore_fpu_error_out_oe,
  output logic                    o_init_out_o,
  output logic                    o_init_out_oe,
  output logic                    o_cpu_irq_out_o,
  output logic                    o_cpu_irq_out_oe,
  output logic                    o_nmi_out_o,
  output logic                    o_nmi_out_oe,
  output logic                    o_sys_mgmt_irq_out_o,
  output logic                    o_sys_mgmt_irq_out_oe,
  output logic                    o_stop_clock_req_out_o,
  output logic                    o_stop_clock_req_out_oe
);

  // synchronised pin inputs
  logic [5:0]  pins_sync;
  logic        power_good;
  logic        fpu_error;
  logic        kbc_reset;
  logic        mask_gate;
  logic        system_error;
  logic        io_check_error;

  // register state
  logic [7:0]  sys_ctrl;
  logic [7:0]  next_sys_ctrl;
  logic [31:0] gen_ctrl;
  logic [31:0] next_gen_ctrl;
  logic [31:0] next_rdata;

  // behaviour state
  logic        bus_reset;
  logic        next_bus_reset;
  logic        ignore_active;
  logic        next_ignore_active;
  logic        nmi_active;
  logic        next_nmi_active;
  logic        system_error_in_prev;
  logic        io_check_error_in_prev;
  logic        kbc_prev;
  logic        init_active;
  logic        init_trigger;
  logic        fpu_enabled;
  logic        ack_write;

  // next values of the pin flops
  logic        next_fpu_irq;
  logic        next_mask_o;
  logic        next_mask_oe;
  logic        next_sleep_oe;
  logic        next_ignore_o;
  logic        next_ignore_oe;
  logic        next_irq_o;
  logic        next_irq_oe;
  logic        next_nmi_o;
  logic        next_nmi_oe;
  logic        next_smi_oe;
  logic        next_stop_oe;

  function automatic logic wr_hit(input logic [7:0] addr);
    wr_hit = i_reg_wr && (i_reg_addr == addr);
  endfunction

  // active-low pins inverted after the synchroniser
  cpsb_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h36)
  ) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({i_io_check_error_in_n, i_system_error_in_n, i_kbc_mask_gate_in,
                i_kbc_reset_in_n, i_fpu_error_in_n, i_power_good_in}),
    .o_sync   (pins_sync)
  );

  assign power_good     = pins_sync[0];
  assign fpu_error      = ~pins_sync[1];
  assign kbc_reset      = ~pins_sync[2];
  assign mask_gate      = pins_sync[3];
  assign system_error   = ~pins_sync[4];
  assign io_check_error = ~pins_sync[5];

  assign init_trigger = (kbc_reset && !kbc_prev) || i_sw_init_req;

  cpsb_init_pulse #(
    .CYCLES (INIT_CYCLES)
  ) u_init (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_trigger (init_trigger),
    .i_hold    (i_bist_enable && bus_reset),
    .o_active  (init_active)
  );

  assign fpu_enabled = gen_ctrl[`CPSB_GEN_CTRL_FPU_BIT];
  // spelled out: a continuous assign would not wake on signals read inside a function
  assign ack_write   = i_reg_wr && (i_reg_addr == `CPSB_ADDR_FPU_ACK);

  always_comb
  begin
    next_sys_ctrl = sys_ctrl;
    next_gen_ctrl = gen_ctrl;
    next_rdata    = 32'h00000000;
    if (wr_hit(`CPSB_ADDR_SYS_CTRL))
      next_sys_ctrl = i_reg_wdata[7:0];
    if (wr_hit(`CPSB_ADDR_GEN_CTRL))
      next_gen_ctrl = i_reg_wdata;
    // the ack register is write-only and unmapped reads give zero
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `CPSB_ADDR_SYS_CTRL: next_rdata = {24'h000000, sys_ctrl};
        `CPSB_ADDR_GEN_CTRL: next_rdata = gen_ctrl;
        default:             next_rdata = 32'h00000000;
      endcase
    end
  end

  always_comb
  begin
    next_bus_reset = !power_good;

    next_ignore_active = ignore_active;
    if (!fpu_error || !fpu_enabled)
      next_ignore_active = 1'b0;
    else if (ack_write)
      next_ignore_active = 1'b1;

    // disable bit clears
    // an edge in the same cycle as the other source's disable still wins; its own disable masks it
    next_nmi_active = nmi_active;
    if (i_nmi_system_error_in_disable || i_nmi_io_check_error_in_disable)
      next_nmi_active = 1'b0;
    if ((system_error && !system_error_in_prev && !i_nmi_system_error_in_disable) ||
        (io_check_error && !io_check_error_in_prev && !i_nmi_io_check_error_in_disable))
      next_nmi_active = 1'b1;

    next_fpu_irq = fpu_error && fpu_enabled;

    next_mask_o  = 1'b0;
    next_mask_oe = sys_ctrl[`CPSB_SYS_CTRL_MASK_BIT] || mask_gate;

    next_sleep_oe = i_cpu_sleep_enable && i_s1_entry;

    next_ignore_o  = 1'b0;
    next_ignore_oe = next_ignore_active;

    next_irq_o  = 1'b0;
    next_irq_oe = !i_irq_pending;

    // nmi is active high, so it is held low until the event
    next_nmi_o  = 1'b0;
    next_nmi_oe = !next_nmi_active;

    next_smi_oe = |(i_smi_event & i_smi_enable);

    next_stop_oe = i_stop_clock_req && !next_bus_reset;

    if (next_bus_reset)
    begin
      next_mask_o    = i_speed_strap_bits[`CPSB_STRAP_ADDR_MASK];
      next_mask_oe   = i_speed_strap_bits[`CPSB_STRAP_ADDR_MASK];
      next_ignore_o  = i_speed_strap_bits[`CPSB_STRAP_IGNORE_ERR];
      next_ignore_oe = i_speed_strap_bits[`CPSB_STRAP_IGNORE_ERR];
      next_irq_o     = i_speed_strap_bits[`CPSB_STRAP_IRQ];
      next_irq_oe    = i_speed_strap_bits[`CPSB_STRAP_IRQ];
      next_nmi_o     = i_speed_strap_bits[`CPSB_STRAP_NMI];
      next_nmi_oe    = i_speed_strap_bits[`CPSB_STRAP_NMI];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sys_ctrl    <= `CPSB_SYS_CTRL_RESET;
      gen_ctrl    <= `CPSB_GEN_CTRL_RESET;
      o_reg_rdata <= 32'h00000000;
    end
    else
    begin
      sys_ctrl    <= next_sys_ctrl;
      gen_ctrl    <= next_gen_ctrl;
      o_reg_rdata <= next_rdata;
    end
  end

  // reset values assume power is not yet good: bus reset asserted
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bus_reset                 <= 1'b1;
      ignore_active             <= 1'b0;
      nmi_active                <= 1'b0;
      system_error_in_prev                 <= 1'b0;
      io_check_error_in_prev                <= 1'b0;
      kbc_prev                  <= 1'b0;
      o_pci_bus_reset_n         <= 1'b0;
      o_fpu_irq_line            <= 1'b0;
      o_addr_bit20_mask_out_o   <= 1'b0;
      o_addr_bit20_mask_out_oe  <= 1'b0;
      o_cpu_sleep_out_o         <= 1'b0;
      o_cpu_sleep_out_oe        <= 1'b0;
      o_ignore_fpu_error_out_o  <= 1'b0;
      o_ignore_fpu_error_out_oe <= 1'b0;
      o_init_out_o              <= 1'b0;
      o_init_out_oe             <= 1'b0;
      o_cpu_irq_out_o           <= 1'b0;
      o_cpu_irq_out_oe          <= 1'b1;
      o_nmi_out_o               <= 1'b0;
      o_nmi_out_oe              <= 1'b1;
      o_sys_mgmt_irq_out_o      <= 1'b0;
      o_sys_mgmt_irq_out_oe     <= 1'b0;
      o_stop_clock_req_out_o    <= 1'b0;
      o_stop_clock_req_out_oe   <= 1'b0;
    end
    else
    begin
      bus_reset                 <= next_bus_reset;
      ignore_active             <= next_ignore_active;
      nmi_active                <= next_nmi_active;
      system_error_in_prev                 <= system_error;
      io_check_error_in_prev                <= io_check_error;
      kbc_prev                  <= kbc_reset;
      o_pci_bus_reset_n         <= !next_bus_reset;
      o_fpu_irq_line            <= next_fpu_irq;
      o_addr_bit20_mask_out_o   <= next_mask_o;
      o_addr_bit20_mask_out_oe  <= next_mask_oe;
      o_cpu_sleep_out_o         <= 1'b0;
      o_cpu_sleep_out_oe        <= next_sleep_oe;
      o_ignore_fpu_error_out_o  <= next_ignore_o;
      o_ignore_fpu_error_out_oe <= next_ignore_oe;
      o_init_out_o              <= 1'b0;
      o_init_out_oe             <= init_active;
      o_cpu_irq_out_o           <= next_irq_o;
      o_cpu_irq_out_oe          <= next_irq_oe;
      o_nmi_out_o               <= next_nmi_o;
      o_nmi_out_oe              <= next_nmi_oe;
      o_sys_mgmt_irq_out_o      <= 1'b0;
      o_sys_mgmt_irq_out_oe     <= next_smi_oe;
      o_stop_clock_req_out_o    <= 1'b0;
      o_stop_clock_req_out_oe   <= next_stop_oe;
    end
  end

endmodule

//--- cpsb_top_asserts.sv
module cpsb_top_asserts
  import cpsb_pkg::*;
#(
  parameter int SMI_SRC     = 4,
  parameter int INIT_CYCLES = 16
)
(
  input wire logic               i_clk,
  input wire logic               i_resetn,
  input wire logic               i_kbc_mask_gate_in,
  input wire logic               i_fpu_error_in_n,
  input wire logic               i_system_error_in_n,
  input wire logic [3:0]         i_speed_strap_bits,
  input wire logic               i_bist_enable,
  input wire logic               i_irq_pending,
  input wire logic               i_nmi_system_error_in_disable,
  input wire logic               i_nmi_io_check_error_in_disable,
  input wire logic [SMI_SRC-1:0] i_smi_event,
  input wire logic [SMI_SRC-1:0] i_smi_enable,
  input wire logic               o_pci_bus_reset_n,
  input wire logic               o_addr_bit20_mask_out_o,
  input wire logic               o_addr_bit20_mask_out_oe,
  input wire logic               o_ignore_fpu_error_out_o,
  input wire logic               o_ignore_fpu_error_out_oe,
  input wire logic               o_init_out_oe,
  input wire logic               o_cpu_irq_out_o,
  input wire logic               o_cpu_irq_out_oe,
  input wire logic               o_nmi_out_o,
  input wire logic               o_nmi_out_oe,
  input wire logic               o_sys_mgmt_irq_out_o,
  input wire logic               o_sys_mgmt_irq_out_oe,
  input wire logic               o_stop_clock_req_out_oe
);
  logic [7:0] init_len;
  logic       init_clean;
  logic       smi_any;

  assign smi_any = |(i_smi_event & i_smi_enable);

  // pulses that overlap bus reset are bist holds, so their length is not judged
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      init_len   <= 8'h00;
      init_clean <= 1'b0;
    end
    else
    begin
      init_len   <= o_init_out_oe ? init_len + 8'h01 : 8'h00;
      init_clean <= o_pci_bus_reset_n && (init_clean || !o_init_out_oe);
    end
  end

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_gate_mask;
    (i_kbc_mask_gate_in && o_pci_bus_reset_n) [*3] |=>
      o_addr_bit20_mask_out_oe && !o_addr_bit20_mask_out_o;
  endproperty
  a_gate_mask: assert property (p_gate_mask)
    else $error("mask pin not driven with gate high");

  property p_strap;
    !o_pci_bus_reset_n && !$past(o_pci_bus_reset_n) && $past(i_resetn) |->
      {o_nmi_out_o, o_cpu_irq_out_o, o_ignore_fpu_error_out_o, o_addr_bit20_mask_out_o}
      == $past(i_speed_strap_bits);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap drive differs from strap bits");

  property p_ign_cause;
    o_ignore_fpu_error_out_oe && !o_ignore_fpu_error_out_o |-> !$past(i_fpu_error_in_n, 3);
  endproperty
  a_ign_cause: assert property (p_ign_cause)
    else $error("ignore-error driven without fpu error");

  property p_init_len;
    $fell(o_init_out_oe) && init_clean |-> init_len == INIT_CYCLES;
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("init pulse length wrong");

  property p_bist_hold;
    (!o_pci_bus_reset_n && i_bist_enable) [*2] |=> o_init_out_oe;
  endproperty
  a_bist_hold: assert property (p_bist_hold)
    else $error("init not held during bus reset");

  property p_irq;
    o_pci_bus_reset_n && $past(o_pci_bus_reset_n) |->
      !o_cpu_irq_out_o && (o_cpu_irq_out_oe != $past(i_irq_pending));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq pin does not follow pending");

  property p_nmi_rise;
    i_system_error_in_n && o_pci_bus_reset_n ##1
      (!i_system_error_in_n && !i_nmi_system_error_in_disable && !i_nmi_io_check_error_in_disable) [*3]
      |-> ##[1:3] !o_nmi_out_oe;
  endproperty
  a_nmi_rise: assert property (p_nmi_rise)
    else $error("nmi not released on system error");

  property p_nmi_clear;
    (i_nmi_system_error_in_disable && i_nmi_io_check_error_in_disable && o_pci_bus_reset_n) [*2] |=>
      o_nmi_out_oe && !o_nmi_out_o;
  endproperty
  a_nmi_clear: assert property (p_nmi_clear)
    else $error("nmi not cleared by disable");

  property p_smi;
    o_pci_bus_reset_n [*2] |->
      (o_sys_mgmt_irq_out_oe == $past(smi_any)) && !o_sys_mgmt_irq_out_o;
  endproperty
  a_smi: assert property (p_smi)
    else $error("smi pin does not follow enabled events");

  property p_stop_float;
    !o_pci_bus_reset_n && !$past(o_pci_bus_reset_n) |-> !o_stop_clock_req_out_oe;
  endproperty
  a_stop_float: assert property (p_stop_float)
    else $error("stop-clock driven during bus reset");
endmodule

bind cpsb_top cpsb_top_asserts #(
  .SMI_SRC     (SMI_SRC),
  .INIT_CYCLES (INIT_CYCLES)
) u_chk (.*);

//--- cpsb_host_model.sv
module cpsb_host_model
  import cpsb_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_fpu_err,
  input  wire logic i_kbc_rst,
  input  wire logic i_kbc_gate,
  input  wire logic i_stop_o,
  input  wire logic i_stop_oe,
  input  wire logic i_nmi_o,
  input  wire logic i_nmi_oe,
  output logic      o_fpu_error_in_n,
  output logic      o_kbc_reset_in_n,
  output logic      o_kbc_mask_gate_in,
  output logic      o_halted,
  output int        o_nmi_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stop_wire;
  logic nmi_wire;
  logic nmi_prev = 1'b1;
  int   nmi_count = 0;

  assign o_nmi_seen = nmi_count;
  assign stop_wire = i_stop_oe ? i_stop_o : 1'b1;
  assign nmi_wire  = i_nmi_oe ? i_nmi_o : 1'b1;
  assign o_fpu_error_in_n   = !i_fpu_err;
  assign o_kbc_reset_in_n   = !i_kbc_rst;
  assign o_kbc_mask_gate_in = i_kbc_gate;

  always @(posedge i_clk)
  begin
    o_halted <= !stop_wire;
    nmi_prev <= nmi_wire;
    if (nmi_wire && !nmi_prev)
      nmi_count <= nmi_count + 1;
  end
endmodule

//--- tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] i_reg_wdata, o_reg_rdata;
  logic [7:0]  i_reg_addr;
  logic [3:0]  i_speed_strap_bits, i_smi_event, i_smi_enable;
  logic        i_clk, i_resetn, i_reg_wr, i_reg_rd, i_power_good_in, i_fpu_error_in_n;
  logic        i_kbc_reset_in_n, i_kbc_mask_gate_in, i_system_error_in_n, i_io_check_error_in_n;
  logic        i_bist_enable, i_sw_init_req, i_cpu_sleep_enable, i_s1_entry, i_irq_pending;
  logic        i_nmi_system_error_in_disable, i_nmi_io_check_error_in_disable, i_stop_clock_req, o_pci_bus_reset_n;
  logic        o_fpu_irq_line, o_addr_bit20_mask_out_o, o_addr_bit20_mask_out_oe;
  logic        o_cpu_sleep_out_o, o_cpu_sleep_out_oe, o_ignore_fpu_error_out_o;
  logic        o_ignore_fpu_error_out_oe, o_init_out_o, o_init_out_oe, o_cpu_irq_out_o;
  logic        o_cpu_irq_out_oe, o_nmi_out_o, o_nmi_out_oe, o_sys_mgmt_irq_out_o;
  logic        o_sys_mgmt_irq_out_oe, o_stop_clock_req_out_o, o_stop_clock_req_out_oe;
  logic        fe, kr, gt, halted;
  int          miscompares, checked, nmi_seen, n, base;

  cpsb_top #(.SMI_SRC(4), .INIT_CYCLES(16)) dut (.*);

  cpsb_host_model u_host (
    .i_clk              (i_clk),
    .i_fpu_err          (fe),
    .i_kbc_rst          (kr),
    .i_kbc_gate         (gt),
    .i_stop_o           (o_stop_clock_req_out_o),
    .i_stop_oe          (o_stop_clock_req_out_oe),
    .i_nmi_o            (o_nmi_out_o),
    .i_nmi_oe           (o_nmi_out_oe),
    .o_fpu_error_in_n   (i_fpu_error_in_n),
    .o_kbc_reset_in_n   (i_kbc_reset_in_n),
    .o_kbc_mask_gate_in (i_kbc_mask_gate_in),
    .o_halted           (halted),
    .o_nmi_seen         (nmi_seen)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = !i_clk;
  end

  task step(input int c);
    repeat (c) @(posedge i_clk);
    #5;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobes drop and a cycle passes, so calls may follow each other directly
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr    = 1'b1;
    step(1);
    i_reg_wr    = 1'b0;
    step(1);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    i_reg_addr = a;
    i_reg_rd   = 1'b1;
    step(1);
    i_reg_rd   = 1'b0;
    chk(o_reg_rdata, exp);
    step(1);
  endtask

  task init_len(output int len);
    len = 0;
    repeat (40)
    begin
      len += int'(o_init_out_oe);
      step(1);
    end
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge i_clk);
    miscompares++;
    print_verdict;
  end

  initial
  begin
    {i_resetn, i_reg_wr, i_reg_rd, i_sw_init_req, i_cpu_sleep_enable, i_s1_entry} = 6'h00;
    {i_irq_pending, i_nmi_system_error_in_disable, i_nmi_io_check_error_in_disable, i_stop_clock_req} = 4'h0;
    {i_power_good_in, i_bist_enable, i_system_error_in_n, i_io_check_error_in_n} = 4'hf;
    {fe, kr, gt} = 3'h0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 32'h0;
    i_speed_strap_bits = 4'ha;
    i_smi_event = 4'h0;
    i_smi_enable = 4'h0;
    miscompares = 0;
    checked = 0;
    repeat (6) @(posedge i_clk);
    #5;
    i_resetn = 1'b1;
    step(2);
    chk({o_nmi_out_o, o_cpu_irq_out_o, o_ignore_fpu_error_out_o, o_addr_bit20_mask_out_o}, 4'ha);
    chk({o_nmi_out_oe, o_cpu_irq_out_oe, o_ignore_fpu_error_out_oe, o_addr_bit20_mask_out_oe}, 4'ha);
    chk({o_init_out_oe, o_stop_clock_req_out_oe}, 2'b10);
    i_bist_enable = 1'b0;
    step(3);
    chk(o_pci_bus_reset_n, 1'b1);
    $display("reset test done");
    rd(8'h92, 32'h0);
    rd(8'hd0, 32'h0);
    wr(8'hd0, 32'hf0f02000);
    wr(8'h55, 32'h2);
    rd(8'hd0, 32'hf0f02000);
    rd(8'hf0, 32'h0);
    rd(8'h55, 32'h0);
    wr(8'h92, 32'h2);
    rd(8'h92, 32'h2);
    chk(o_addr_bit20_mask_out_oe, 1'b1);
    wr(8'h92, 32'h0);
    chk(o_addr_bit20_mask_out_oe, 1'b0);
    gt = 1'b1;
    step(4);
    chk(o_addr_bit20_mask_out_oe, 1'b1);
    gt = 1'b0;
    step(4);
    chk(o_addr_bit20_mask_out_oe, 1'b0);
    $display("register and mask test done");
    fe = 1'b1;
    step(4);
    chk({o_fpu_irq_line, o_ignore_fpu_error_out_oe}, 2'b10);
    wr(8'hf0, 32'h0);
    chk(o_ignore_fpu_error_out_oe, 1'b1);
    fe = 1'b0;
    step(4);
    chk({o_fpu_irq_line, o_ignore_fpu_error_out_oe}, 2'b00);
    wr(8'hf0, 32'h0);
    chk(o_ignore_fpu_error_out_oe, 1'b0);
    wr(8'hd0, 32'h0);
    fe = 1'b1;
    step(4);
    wr(8'hf0, 32'h0);
    chk({o_fpu_irq_line, o_ignore_fpu_error_out_oe}, 2'b00);
    fe = 1'b0;
    $display("fpu error test done");
    i_sw_init_req = 1'b1;
    step(1);
    i_sw_init_req = 1'b0;
    init_len(n);
    chk(n, 16);
    kr = 1'b1;
    init_len(n);
    kr = 1'b0;
    chk(n, 16);
    $display("init test done");
    i_irq_pending = 1'b1;
    step(1);
    chk({o_cpu_irq_out_oe, o_cpu_irq_out_o}, 2'b00);
    i_irq_pending = 1'b0;
    step(1);
    chk(o_cpu_irq_out_oe, 1'b1);
    for (int s = 0; s < 2; s++)
    begin
      base = nmi_seen;
      {i_io_check_error_in_n, i_system_error_in_n} = ~(2'b01 << s);
      step(6);
      chk(nmi_seen - base, 1);
      {i_io_check_error_in_n, i_system_error_in_n} = 2'b11;
      {i_nmi_io_check_error_in_disable, i_nmi_system_error_in_disable} = 2'b01 << s;
      step(2);
      chk({o_nmi_out_oe, o_nmi_out_o}, 2'b10);
      {i_nmi_io_check_error_in_disable, i_nmi_system_error_in_disable} = 2'b00;
    end
    {i_nmi_io_check_error_in_disable, i_nmi_system_error_in_disable} = 2'b11;
    step(3);
    chk(o_nmi_out_oe, 1'b1);
    {i_nmi_io_check_error_in_disable, i_nmi_system_error_in_disable} = 2'b00;
    $display("interrupt test done");
    i_smi_event = 4'h5;
    i_smi_enable = 4'h4;
    step(2);
    chk({o_sys_mgmt_irq_out_oe, o_sys_mgmt_irq_out_o}, 2'b10);
    i_smi_enable = 4'ha;
    step(2);
    chk(o_sys_mgmt_irq_out_oe, 1'b0);
    i_stop_clock_req = 1'b1;
    step(2);
    chk({o_stop_clock_req_out_oe, halted}, 2'b11);
    {i_cpu_sleep_enable, i_s1_entry} = 2'b11;
    step(2);
    chk(o_cpu_sleep_out_oe, 1'b1);
    chk({o_cpu_sleep_out_o, o_stop_clock_req_out_o, o_init_out_o}, 3'b000);
    i_s1_entry = 1'b0;
    step(2);
    chk(o_cpu_sleep_out_oe, 1'b0);
    i_power_good_in = 1'b0;
    step(5);
    chk({o_pci_bus_reset_n, o_stop_clock_req_out_oe}, 2'b00);
    i_power_good_in = 1'b1;
    step(6);
    chk(o_stop_clock_req_out_oe, 1'b1);
    i_stop_clock_req = 1'b0;
    $display("power test done");
    print_verdict;
  end
endmodule
